// File: common/asm_pkg.sv
package asm_pkg;
    // register addresses on the serial port
    localparam logic [5:0] ADDR_STATUS = 6'h01;
    localparam logic [5:0] ADDR_MODE = 6'h02;

    localparam logic [15:0] STATUS_RESET = 16'h0500;
    localparam logic [15:0] MODE_RESET = 16'h0510;
    // bits 15:14 are not stored
    localparam logic [15:0] MODE_WRITE_MASK = 16'h3fff;

    localparam int ST_LOCK = 15;
    localparam int ST_RESYNC = 14;
    localparam int ST_REGMAP = 13;
    localparam int ST_CRC_ERR = 12;
    localparam int ST_CRC_TYPE = 11;
    localparam int ST_RESET = 10;
    localparam int ST_WLEN_LO = 8;

    localparam int MD_REG_CRC_EN = 13;
    localparam int MD_RX_CRC_EN = 12;
    localparam int MD_CRC_TYPE = 11;
    localparam int MD_RESET = 10;
    localparam int MD_WLEN_LO = 8;
    localparam int MD_TIMEOUT = 4;
    localparam int MD_SRC_LO = 2;
    localparam int MD_FLOAT = 1;
    localparam int MD_PULSE = 0;

    // frame: 8 command bits (write, spare, 6 address bits), 16 data bits
    localparam int CMD_WRITE = 7;
    localparam logic [4:0] CMD_LAST_BIT = 5'h07;
    localparam logic [4:0] FRAME_LAST_BIT = 5'h17;
    localparam logic [4:0] FRAME_BITS = 5'h18;
    localparam logic [4:0] FIRST_DATA_SHIFT = 5'h09;

    localparam logic [1:0] SRC_LAGGING = 2'h0;
    localparam logic [1:0] SRC_OR = 2'h1;

    localparam int CLK_PERIOD_NS = 10;
    localparam int PULSE_TIME_NS = 100;
    localparam int PULSE_CYCLES = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMEOUT_TIME_NS = 1000000;
    localparam int TIMEOUT_CYCLES = TIMEOUT_TIME_NS / CLK_PERIOD_NS;

    localparam logic [2:0] SYNC_RESET = 3'h1;

    // set wins over clear
    function automatic logic sticky(input logic set, input logic clr, input logic q);
        sticky = set | (q & ~clr);
    endfunction
endpackage

// File: logic/asm_sync3.sv
`timescale 1ns/1ps
module asm_sync3 (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [2:0] raw_in,
    output logic [2:0] stable_out
);
    logic [2:0] s1_r;
    logic [2:0] s2_r;
    logic [2:0] s3_r;
    logic [2:0] stable_nxt;

    // a bit moves only once the last two stages agree
    assign stable_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & stable_out);

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            s1_r <= asm_pkg::SYNC_RESET;
            s2_r <= asm_pkg::SYNC_RESET;
            s3_r <= asm_pkg::SYNC_RESET;
            stable_out <= asm_pkg::SYNC_RESET;
        end else begin
            s1_r <= raw_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            stable_out <= stable_nxt;
        end
    end
endmodule

// File: logic/asm_ready_pin.sv
`timescale 1ns/1ps
module asm_ready_pin (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [5:0] new_data_in,
    input wire logic [5:0] chan_enable_in,
    input wire logic [1:0] source_in,
    input wire logic idle_float_in,
    input wire logic pulse_format_in,
    output logic pin_out,
    output logic pin_oe_out
);
    localparam logic [3:0] PULSE_LOAD = 4'(asm_pkg::PULSE_CYCLES);

    logic [5:0] hits;
    logic all_in;
    logic any_in;
    logic avail;
    logic avail_prev_r;
    logic [3:0] pulse_cnt_r;
    logic drive_low;

    assign hits = new_data_in & chan_enable_in;
    assign all_in = (chan_enable_in != 6'h00) && (hits == chan_enable_in);
    assign any_in = hits != 6'h00;
    // source select
    // leading channel is the first to report, so any enabled one
    assign avail = (source_in == asm_pkg::SRC_LAGGING) ? all_in : any_in;
    assign drive_low = pulse_format_in ? (pulse_cnt_r != 4'h0) : avail;

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            avail_prev_r <= 1'b0;
            pulse_cnt_r <= 4'h0;
            pin_out <= 1'b1;
            pin_oe_out <= 1'b1;
        end else begin
            avail_prev_r <= avail;
            if (avail && !avail_prev_r) begin
                pulse_cnt_r <= PULSE_LOAD;
            end else if (pulse_cnt_r != 4'h0) begin
                pulse_cnt_r <= pulse_cnt_r - 4'h1;
            end
            pin_out <= ~drive_low;
            pin_oe_out <= drive_low | ~idle_float_in;
        end
    end
endmodule

// File: logic/asm_regs_top.sv
`timescale 1ns/1ps
// Summary of operation
// - status at 0x01, resets to 0x0500
// - mode at 0x02, resets 0x0510, read/write
// - bit 15 shows interface lock
// - bit 14 set on every resync
// - bit 13 flags configuration checksum change
// - bit 12 flags host data checksum error
// - bit 11 reports checksum polynomial
// - bit 10 set after reset
// - writing mode bit 10 zero clears it
// - bits 9:8 report active word length
// - mode bits 9:8 select word length
// - bits 5:0 per-channel new data
// - mode bit 13 enables configuration checksum
// - mode bit 12 enables input checksum
// - mode bit 11 selects polynomial
// - mode 3:2 select ready pin source
// - mode bit 1 floats idle pin
// - mode bit 0 selects pulse format
module asm_regs_top #(
    parameter int unsigned TIMEOUT_CYCLES = asm_pkg::TIMEOUT_CYCLES
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_sclk_in,
    input wire logic spi_din_in,
    output logic spi_dout_out,
    output logic spi_dout_oe_out,
    input wire logic lock_in,
    input wire logic resync_in,
    input wire logic regmap_crc_changed_in,
    input wire logic input_crc_error_in,
    input wire logic [5:0] chan_new_data_in,
    input wire logic [5:0] chan_enable_in,
    output logic reg_crc_enable_out,
    output logic input_crc_enable_out,
    output logic crc_poly_ansi_out,
    output logic [1:0] word_size_select_out,
    output logic timeout_enable_out,
    output logic sample_ready_pin_out,
    output logic sample_ready_pin_oe_out
);
    localparam logic [19:0] TIMEOUT_LAST = 20'(TIMEOUT_CYCLES - 1);

    // synchronised pins: bit 0 select, bit 1 clock, bit 2 data
    logic [2:0] pins_raw;
    logic [2:0] pins_s;
    logic cs_s;
    logic sclk_s;
    logic din_s;

    logic sclk_prev_r;
    logic sclk_rise;
    logic sclk_fall;
    logic [4:0] bit_cnt_r;
    logic [23:0] shift_in_r;
    logic [23:0] shift_in_nxt;
    logic [15:0] tx_r;
    logic [5:0] addr_r;
    logic write_cmd_r;
    logic load_pend_r;
    logic [19:0] idle_cnt_r;
    logic timed_out;
    logic frame_end;
    logic frame_write;
    logic [5:0] frame_addr;
    logic [15:0] frame_data;
    logic wr_mode;
    logic status_read;

    logic [15:0] mode_r;
    logic [15:0] mode_nxt;
    logic lock_r;
    logic resync_flag_r;
    logic regmap_flag_r;
    logic crc_err_flag_r;
    logic reset_flag_r;
    logic [5:0] new_data_r;
    logic [15:0] status_word;
    logic [15:0] rd_data;
    logic regmap_set;
    logic crc_err_set;
    logic reset_clr;

    assign pins_raw = {spi_din_in, spi_sclk_in, spi_cs_n_in};

    asm_sync3 u_sync (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .raw_in(pins_raw),
        .stable_out(pins_s)
    );

    assign cs_s = pins_s[0];
    assign sclk_s = pins_s[1];
    assign din_s = pins_s[2];
    assign sclk_rise = !cs_s && sclk_s && !sclk_prev_r;
    assign sclk_fall = !cs_s && !sclk_s && sclk_prev_r;

    assign shift_in_nxt = {shift_in_r[22:0], din_s};
    assign frame_end = sclk_rise && (bit_cnt_r == asm_pkg::FRAME_LAST_BIT);
    assign frame_write = shift_in_nxt[16 + asm_pkg::CMD_WRITE];
    assign frame_addr = shift_in_nxt[21:16];
    assign frame_data = shift_in_nxt[15:0];

    assign timed_out = mode_r[asm_pkg::MD_TIMEOUT] && !cs_s && (bit_cnt_r != 5'h00)
        && (idle_cnt_r == TIMEOUT_LAST);

    // status address never decoded for write
    assign wr_mode = frame_end && frame_write && (frame_addr == asm_pkg::ADDR_MODE);
    assign status_read = load_pend_r && !write_cmd_r && (addr_r == asm_pkg::ADDR_STATUS);

    assign status_word = {lock_r, resync_flag_r, regmap_flag_r, crc_err_flag_r,
        mode_r[asm_pkg::MD_CRC_TYPE], reset_flag_r,
        mode_r[asm_pkg::MD_WLEN_LO +: 2], 2'h0, new_data_r};

    assign rd_data = (addr_r == asm_pkg::ADDR_STATUS) ? status_word :
        (addr_r == asm_pkg::ADDR_MODE) ? mode_r : 16'h0000;

    // upper reserved bits dropped; 7:5 kept as written
    assign mode_nxt = frame_data & asm_pkg::MODE_WRITE_MASK;

    assign regmap_set = regmap_crc_changed_in && mode_r[asm_pkg::MD_REG_CRC_EN];
    assign crc_err_set = input_crc_error_in && mode_r[asm_pkg::MD_RX_CRC_EN];
    // zero in bit 10 clears flag
    assign reset_clr = wr_mode && !frame_data[asm_pkg::MD_RESET];

    // serial frame engine
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            sclk_prev_r <= 1'b0;
            bit_cnt_r <= 5'h00;
            shift_in_r <= 24'h000000;
            tx_r <= 16'h0000;
            addr_r <= 6'h00;
            write_cmd_r <= 1'b0;
            load_pend_r <= 1'b0;
            idle_cnt_r <= 20'h00000;
            spi_dout_oe_out <= 1'b0;
        end else begin
            sclk_prev_r <= sclk_s;
            spi_dout_oe_out <= !cs_s;
            if (cs_s || timed_out) begin
                bit_cnt_r <= 5'h00;
                tx_r <= 16'h0000;
                load_pend_r <= 1'b0;
                idle_cnt_r <= 20'h00000;
            end else begin
                if (sclk_rise || sclk_fall) begin
                    idle_cnt_r <= 20'h00000;
                end else if (idle_cnt_r != TIMEOUT_LAST) begin
                    idle_cnt_r <= idle_cnt_r + 20'h00001;
                end
                if (sclk_rise && bit_cnt_r != asm_pkg::FRAME_BITS) begin
                    shift_in_r <= shift_in_nxt;
                    bit_cnt_r <= bit_cnt_r + 5'h01;
                end
                if (sclk_rise && bit_cnt_r == asm_pkg::CMD_LAST_BIT) begin
                    addr_r <= shift_in_nxt[5:0];
                    write_cmd_r <= shift_in_nxt[asm_pkg::CMD_WRITE];
                    load_pend_r <= 1'b1;
                end else if (load_pend_r) begin
                    load_pend_r <= 1'b0;
                end
                // load lags the command by a cycle so the decode sees the new address
                if (load_pend_r) begin
                    tx_r <= write_cmd_r ? 16'h0000 : rd_data;
                end else if (sclk_fall && bit_cnt_r >= asm_pkg::FIRST_DATA_SHIFT) begin
                    tx_r <= {tx_r[14:0], 1'b0};
                end
            end
        end
    end

    assign spi_dout_out = tx_r[15];

    // mode register
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            mode_r <= asm_pkg::MODE_RESET;
        end else if (wr_mode) begin
            mode_r <= mode_nxt;
        end
    end

    // status flags; read of status clears the sticky events
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            lock_r <= 1'b0;
            resync_flag_r <= 1'b0;
            regmap_flag_r <= 1'b0;
            crc_err_flag_r <= 1'b0;
            reset_flag_r <= 1'b1;
            new_data_r <= 6'h00;
        end else begin
            lock_r <= lock_in;
            resync_flag_r <= asm_pkg::sticky(resync_in, status_read, resync_flag_r);
            regmap_flag_r <= asm_pkg::sticky(regmap_set, status_read, regmap_flag_r);
            crc_err_flag_r <= asm_pkg::sticky(crc_err_set, status_read, crc_err_flag_r);
            reset_flag_r <= reset_flag_r & ~reset_clr;
            new_data_r <= chan_new_data_in;
        end
    end

    // configuration outputs follow the mode bits
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            reg_crc_enable_out <= asm_pkg::MODE_RESET[asm_pkg::MD_REG_CRC_EN];
            input_crc_enable_out <= asm_pkg::MODE_RESET[asm_pkg::MD_RX_CRC_EN];
            crc_poly_ansi_out <= asm_pkg::MODE_RESET[asm_pkg::MD_CRC_TYPE];
            word_size_select_out <= asm_pkg::MODE_RESET[asm_pkg::MD_WLEN_LO +: 2];
            timeout_enable_out <= asm_pkg::MODE_RESET[asm_pkg::MD_TIMEOUT];
        end else begin
            reg_crc_enable_out <= mode_r[asm_pkg::MD_REG_CRC_EN];
            input_crc_enable_out <= mode_r[asm_pkg::MD_RX_CRC_EN];
            crc_poly_ansi_out <= mode_r[asm_pkg::MD_CRC_TYPE];
            word_size_select_out <= mode_r[asm_pkg::MD_WLEN_LO +: 2];
            timeout_enable_out <= mode_r[asm_pkg::MD_TIMEOUT];
        end
    end

    asm_ready_pin u_ready (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .new_data_in(chan_new_data_in),
        .chan_enable_in(chan_enable_in),
        .source_in(mode_r[asm_pkg::MD_SRC_LO +: 2]),
        .idle_float_in(mode_r[asm_pkg::MD_FLOAT]),
        .pulse_format_in(mode_r[asm_pkg::MD_PULSE]),
        .pin_out(sample_ready_pin_out),
        .pin_oe_out(sample_ready_pin_oe_out)
    );
endmodule

// File: verification/asm_regs_asserts.sv
`timescale 1ns/1ps
module asm_regs_asserts #(
    parameter int unsigned TIMEOUT_CYCLES = 50
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_dout_out,
    input wire logic spi_dout_oe_out,
    input wire logic [5:0] chan_new_data_in,
    input wire logic [5:0] chan_enable_in,
    input wire logic reg_crc_enable_out,
    input wire logic input_crc_enable_out,
    input wire logic crc_poly_ansi_out,
    input wire logic [1:0] word_size_select_out,
    input wire logic timeout_enable_out,
    input wire logic sample_ready_pin_out,
    input wire logic sample_ready_pin_oe_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    logic [5:0] avail;
    logic [5:0] mode_outs;
    assign avail = chan_new_data_in & chan_enable_in;
    assign mode_outs = {reg_crc_enable_out, input_crc_enable_out, crc_poly_ansi_out, word_size_select_out,
        timeout_enable_out};

    a_mode_reset_val: assert property ($rose(rstn_in) |-> mode_outs == 6'h03)
        else $error("mode outputs not at reset value");
    a_mode_outs_hold: assert property (spi_cs_n_in [*8] |=> $stable(mode_outs))
        else $error("mode outputs moved outside a frame");
    a_pin_idle_high: assert property ((avail == 6'h00) [*8] ##1 (avail == 6'h00) [*4] |=> sample_ready_pin_out)
        else $error("ready pin low with no data");
    a_low_is_driven: assert property (!sample_ready_pin_out |-> sample_ready_pin_oe_out)
        else $error("ready pin low but not driven");
    a_full_set_low: assert property ((chan_enable_in != 6'h00 && avail == chan_enable_in && $past(avail) == 6'h00)
        |-> ##[1:2] !sample_ready_pin_out)
        else $error("ready pin missed new data");
    a_dout_released: assert property (spi_cs_n_in [*8] |=> !spi_dout_oe_out && !spi_dout_out)
        else $error("serial output active outside a frame");
    a_oe_in_frame: assert property ($fell(spi_cs_n_in) |-> ##[2:8] spi_dout_oe_out)
        else $error("serial output not enabled in frame");
    a_oe_holds: assert property (!spi_cs_n_in [*6] |=> spi_dout_oe_out)
        else $error("serial output dropped within frame");

    cover property (word_size_select_out == 2'h3);
    cover property (!sample_ready_pin_oe_out);
    cover property (!sample_ready_pin_out);
endmodule

bind asm_regs_top asm_regs_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_asm_chk (
    .clk_in, .rstn_in, .spi_cs_n_in, .spi_dout_out, .spi_dout_oe_out, .chan_new_data_in, .chan_enable_in,
    .reg_crc_enable_out, .input_crc_enable_out, .crc_poly_ansi_out, .word_size_select_out,
    .timeout_enable_out, .sample_ready_pin_out, .sample_ready_pin_oe_out
);

// File: verification/asm_host_model.sv
`timescale 1ns/1ps
module asm_host_model (
    output logic cs_n_out,
    output logic sclk_out,
    output logic din_out,
    input wire logic dout_in
);
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        din_out = 1'b0;
    end
    // sclk rests low between frames; msb first, read bits caught on each of the last 16 rises
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, output logic [15:0] rd);
        logic [23:0] word;
        word = {cmd, wd};
        rd = 16'h0000;
        cs_n_out = 1'b0;
        #100;
        for (int i = 23; i >= 0; i--) begin
            din_out = word[i];
            #62.5 sclk_out = 1'b1;
            if (i < 16) rd = {rd[14:0], dout_in};
            #62.5 sclk_out = 1'b0;
        end
        #100 cs_n_out = 1'b1;
        // idle data line flips so a stale bit never looks valid
        din_out = ~din_out;
        #300;
    endtask
    // partial frame left hanging with select still low
    task automatic stub(input int n);
        cs_n_out = 1'b0;
        din_out = 1'b0;
        #100;
        repeat (n) begin
            #62.5 sclk_out = 1'b1;
            #62.5 sclk_out = 1'b0;
        end
        #1000;
    endtask
endmodule

// File: verification/tb_asm_regs_top.sv
`timescale 1ns/1ps
module tb_asm_regs_top;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic lock_in = 1'b0, resync_in = 1'b0, regmap_crc_changed_in = 1'b0, input_crc_error_in = 1'b0;
    logic [5:0] chan_new_data_in = 6'h00, chan_enable_in = 6'h3f;
    logic spi_cs_n_in, spi_sclk_in, spi_din_in, spi_dout_out, spi_dout_oe_out;
    logic reg_crc_enable_out, input_crc_enable_out, crc_poly_ansi_out, timeout_enable_out;
    logic [1:0] word_size_select_out;
    logic sample_ready_pin_out, sample_ready_pin_oe_out;
    int fail_count = 0;
    int samples_checked = 0;
    wire miso = spi_dout_oe_out ? spi_dout_out : 1'bz;
    wire [15:0] outs = {10'h0, reg_crc_enable_out, input_crc_enable_out, crc_poly_ansi_out, word_size_select_out,
        timeout_enable_out};
    wire [15:0] pin_w = {14'h0, sample_ready_pin_out, sample_ready_pin_oe_out};

    always #5 clk_in = ~clk_in;

    asm_regs_top #(.TIMEOUT_CYCLES(50)) DUT (
        .clk_in, .rstn_in, .spi_cs_n_in, .spi_sclk_in, .spi_din_in, .spi_dout_out, .spi_dout_oe_out,
        .lock_in, .resync_in, .regmap_crc_changed_in, .input_crc_error_in, .chan_new_data_in, .chan_enable_in,
        .reg_crc_enable_out, .input_crc_enable_out, .crc_poly_ansi_out, .word_size_select_out,
        .timeout_enable_out, .sample_ready_pin_out, .sample_ready_pin_oe_out
    );
    asm_host_model hm (.cs_n_out(spi_cs_n_in), .sclk_out(spi_sclk_in), .din_out(spi_din_in), .dout_in(miso));

    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp);
        logic [15:0] d;
        tick(1);
        hm.xfer({2'h0, a}, 16'h0000, d);
        check(d, exp);
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] v);
        logic [15:0] d;
        tick(1);
        hm.xfer({2'h2, a}, v, d);
    endtask

    task automatic t_reset;
        rd_chk(asm_pkg::ADDR_STATUS, 16'h0500);
        rd_chk(asm_pkg::ADDR_MODE, 16'h0510);
        check(outs, 16'h0003);
        check(pin_w, 16'h0003);
        $display("t_reset done");
    endtask
    task automatic t_modes;
        logic [15:0] md;
        for (int w = 0; w < 4; w++) begin
            md = {2'h0, w[0], w[1], w[0], 1'b0, w[1:0], 3'h0, w[1], 4'h0};
            wr(asm_pkg::ADDR_MODE, md);
            tick(2);
            rd_chk(asm_pkg::ADDR_MODE, md);
            check(outs, {10'h0, md[13:11], md[9:8], md[4]});
            rd_chk(asm_pkg::ADDR_STATUS, {4'h0, md[11], 1'b0, md[9:8], 8'h00});
        end
        $display("t_modes done");
    endtask
    task automatic t_status_ro;
        wr(asm_pkg::ADDR_STATUS, 16'hffff);
        rd_chk(asm_pkg::ADDR_STATUS, 16'h0b00);
        rd_chk(asm_pkg::ADDR_MODE, 16'h3b10);
        rd_chk(6'h3f, 16'h0000);
        $display("t_status_ro done");
    endtask
    task automatic t_events;
        tick(1);
        lock_in = 1'b1;
        chan_new_data_in = 6'h2a;
        {resync_in, regmap_crc_changed_in, input_crc_error_in} = 3'h7;
        tick(1);
        {resync_in, regmap_crc_changed_in, input_crc_error_in} = 3'h0;
        rd_chk(asm_pkg::ADDR_STATUS, 16'hfb2a);
        rd_chk(asm_pkg::ADDR_STATUS, 16'h8b2a);
        wr(asm_pkg::ADDR_MODE, 16'h0b10);
        tick(1);
        {resync_in, regmap_crc_changed_in, input_crc_error_in} = 3'h7;
        tick(1);
        {resync_in, regmap_crc_changed_in, input_crc_error_in} = 3'h0;
        rd_chk(asm_pkg::ADDR_STATUS, 16'hcb2a);
        tick(1);
        lock_in = 1'b0;
        chan_new_data_in = 6'h00;
        $display("t_events done");
    endtask
    task automatic t_ready;
        wr(asm_pkg::ADDR_MODE, 16'h0112);
        tick(3);
        check(pin_w, 16'h0002);
        chan_new_data_in = 6'h3f;
        tick(3);
        check(pin_w, 16'h0001);
        chan_new_data_in = 6'h1f;
        tick(3);
        check(pin_w, 16'h0002);
        chan_enable_in = 6'h1f;
        tick(3);
        check(pin_w, 16'h0001);
        chan_new_data_in = 6'h00;
        chan_enable_in = 6'h3f;
        wr(asm_pkg::ADDR_MODE, 16'h0115);
        tick(3);
        check(pin_w, 16'h0003);
        chan_new_data_in = 6'h04;
        tick(3);
        check(pin_w, 16'h0001);
        tick(12);
        check(pin_w, 16'h0003);
        for (int s = 2; s < 4; s++) begin
            wr(asm_pkg::ADDR_MODE, {12'h011, s[1:0], 2'h0});
            tick(2);
            check(pin_w, 16'h0001);
        end
        chan_new_data_in = 6'h00;
        $display("t_ready done");
    endtask
    task automatic t_timeout;
        logic [15:0] d;
        for (int e = 1; e >= 0; e--) begin
            wr(asm_pkg::ADDR_MODE, {11'h008, e[0], 4'h0});
            tick(1);
            hm.stub(4);
            hm.xfer({2'h2, asm_pkg::ADDR_MODE}, 16'h0300, d);
            rd_chk(asm_pkg::ADDR_MODE, e[0] ? 16'h0300 : 16'h0100);
        end
        $display("t_timeout done");
    endtask
    task automatic t_rerun;
        rstn_in = 1'b0;
        tick(3);
        rstn_in = 1'b1;
        t_reset();
    endtask

    initial begin
        repeat (3) @(posedge clk_in);
        #1 rstn_in = 1'b1;
        t_reset();
        t_modes();
        t_status_ro();
        t_events();
        t_ready();
        t_timeout();
        t_rerun();
        stop_test();
    end
    initial begin
        #400000;
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test();
    end
endmodule
